/* File: dv/tlsi_lamp_ctrl_properties.sv */
// Port checker for the lamp driver.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
module tlsi_lamp_ctrl_properties #(
  parameter int SEC_DIV = 20
) (
  input wire logic I_SYS_CLK,
  input wire logic I_RST,
  input wire logic i_card_disabled,
  input wire logic i_red_alarm,
  input wire logic i_yellow_alarm,
  input wire logic i_loopback,
  input wire logic i_sch_enabled,
  input wire logic i_sch_test_cmd,
  input wire logic O_CARD_DISABLED_LAMP,
  input wire logic O_CARD_ACTIVE_LAMP,
  input wire logic O_RED_ALARM_LAMP,
  input wire logic O_FAR_END_ALARM_LAMP,
  input wire logic O_LOOPBACK_LAMP,
  input wire logic [1:0] O_CLKC_LAMP,
  input wire logic [1:0] O_SCH_LAMP,
  input wire logic O_SCH_TEST_START,
  input wire logic O_SELFTEST_DONE
);
  import tlsi_pkg::*;
  int cnt;
  wire logic [4:0] lamps = {O_CARD_DISABLED_LAMP, O_CARD_ACTIVE_LAMP, O_RED_ALARM_LAMP, O_FAR_END_ALARM_LAMP,
    O_LOOPBACK_LAMP};
  wire logic up = O_SELFTEST_DONE;
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (I_RST);
  // Cycles since reset release; margins allow for the prescaler restart
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) cnt <= 0;
    else if (cnt < 100000) cnt <= cnt + 1;
  end
  a_all_on_hold: assert property (cnt >= 1 && cnt <= 11 * SEC_DIV - 2 |-> lamps == 5'h1F)
    else $error("main lamps not all lit");
  a_all_off_gap: assert property (cnt >= 11 * SEC_DIV + 3 && cnt <= 12 * SEC_DIV - 2 |-> lamps == 5'h00)
    else $error("main lamps not all dark");
  a_done_sticks: assert property (up |=> up)
    else $error("done dropped");
  a_disabled_follow: assert property (up && $past(up) |-> O_CARD_DISABLED_LAMP == $past(i_card_disabled))
    else $error("disabled lamp wrong");
  a_active_follow: assert property (up && $past(up) |-> O_CARD_ACTIVE_LAMP ==
    $past(!(i_card_disabled | i_red_alarm | i_yellow_alarm | i_loopback))) else $error("active lamp wrong");
  a_alarm_follow: assert property (up && $past(up) |-> O_RED_ALARM_LAMP == $past(i_red_alarm))
    else $error("red alarm lamp wrong");
  a_far_end_follow: assert property (up && $past(up) |-> O_FAR_END_ALARM_LAMP == $past(i_yellow_alarm))
    else $error("far end lamp wrong");
  a_loop_follow: assert property (up && $past(up) |-> O_LOOPBACK_LAMP == $past(i_loopback))
    else $error("loopback lamp wrong");
  a_clkc_dark: assert property (cnt >= 1 && cnt <= 2 * SEC_DIV - 2 |-> O_CLKC_LAMP == LAMP_DARK)
    else $error("clock lamp lit early");
  a_sch_colour: assert property (!$past(I_RST) |-> O_SCH_LAMP ==
    ($past(i_sch_enabled) ? LAMP_GREEN : LAMP_RED)) else $error("handler lamp wrong");
  a_test_only_cmd: assert property (O_SCH_TEST_START |-> $past(i_sch_test_cmd) && !$past(i_sch_test_cmd, 2))
    else $error("test start without command");
endmodule

/* File: dv/tlsi_lamp_watch.sv */
// Faceplate lamp observer that counts the lamp flashes of the power-on test.
// Assumes it shares the card clock and reset with the lamp driver.
`timescale 1ns/100ps
module tlsi_lamp_watch (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_main_lamp,
  input wire logic i_clkc_red,
  input wire logic i_done,
  output logic [3:0] o_main_rises,
  output logic [3:0] o_clkc_rises
);
  logic main_d;
  logic red_d;
  // Counts rising edges only, so a steady lamp counts once
  always_ff @(posedge i_clk) begin
    main_d <= i_main_lamp;
    red_d <= i_clkc_red;
    if (i_rst) begin
      o_main_rises <= 4'h0;
      o_clkc_rises <= 4'h0;
    end else begin
      if (i_main_lamp && !main_d && !i_done) o_main_rises <= o_main_rises + 4'h1;
      if (i_clkc_red && !red_d) o_clkc_rises <= o_clkc_rises + 4'h1;
    end
  end
endmodule

/* File: dv/trunk_card_led_selftest_indicator_tb.sv */
// Self-checking bench for the lamp driver with shortened timebase.
// Assumes the lamp observer and checker files are compiled first.
`timescale 1ns/100ps
module trunk_card_led_selftest_indicator_tb;
  import tlsi_pkg::*;
  logic clk = 1'b0, rst = 1'b1, dis = 1'b1, ral = 1'b0, yal = 1'b0, loopback_lamp = 1'b0, pf = 1'b0;
  logic cp = 1'b1, cen = 1'b0, cfg = 1'b0, sen = 1'b0, cmd = 1'b0;
  logic l_dis, l_act, l_red, l_yel, l_lbk, st, done, seen_g, seen_d;
  logic [1:0] l_clk, l_sch;
  logic [3:0] m_rise, c_rise;
  int mismatches = 0, tests_run = 0, pulses = 0;
  always #5 clk = ~clk;
  always @(posedge clk) if (st === 1'b1) pulses <= pulses + 1;
  tlsi_lamp_ctrl #(.SEC_DIV(20), .BLINK_DIV(5)) i_dut (.I_SYS_CLK(clk), .I_RST(rst), .i_card_disabled(dis),
    .i_red_alarm(ral), .i_yellow_alarm(yal), .i_loopback(loopback_lamp), .i_test_partial_fail(pf), .i_clkc_test_pass(cp),
    .i_clkc_enabled(cen), .i_clkc_flash_green(cfg), .i_sch_enabled(sen), .i_sch_test_cmd(cmd),
    .O_CARD_DISABLED_LAMP(l_dis), .O_CARD_ACTIVE_LAMP(l_act), .O_RED_ALARM_LAMP(l_red),
    .O_FAR_END_ALARM_LAMP(l_yel), .O_LOOPBACK_LAMP(l_lbk), .O_CLKC_LAMP(l_clk), .O_SCH_LAMP(l_sch),
    .O_SCH_TEST_START(st), .O_SELFTEST_DONE(done));
  tlsi_lamp_watch i_watch (.i_clk(clk), .i_rst(rst), .i_main_lamp(l_lbk), .i_clkc_red(l_clk[0]),
    .i_done(done), .o_main_rises(m_rise), .o_clkc_rises(c_rise));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task chk(input string nm, input logic [4:0] exp, input logic [4:0] got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task conclude;
    if (mismatches == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Reset for 21 cycles, then wait for the sequence with a bound
  task power_up(input logic fail, input logic pass);
    @(posedge clk);
    rst <= 1'b1;
    pf <= fail;
    cp <= pass;
    tick(20);
    @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 2000 && done !== 1'b1; i++) tick(1);
    if (done !== 1'b1) begin
      mismatches++;
      $display("[FAIL] selftest done expected 1 seen %b", done);
      conclude();
    end
    tick(2);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    power_up(1'b0, 1'b1);
    chk("pass flashes", 5'h04, {1'b0, m_rise});
    chk("clock red flashes", 5'h03, {1'b0, c_rise});
    chk("clock steady red", {3'h0, LAMP_RED}, {3'h0, l_clk});
    chk("handler red", {3'h0, LAMP_RED}, {3'h0, l_sch});
    // Every status combination, counting down so the last one clears all four inputs
    for (int i = 15; i >= 0; i--) begin
      @(posedge clk);
      {dis, ral, yal, loopback_lamp} <= i[3:0];
      tick(2);
      chk("main lamps", {i[3], i[3:0] == 4'h0, i[2], i[1], i[0]}, {l_dis, l_act, l_red, l_yel, l_lbk});
    end
    @(posedge clk);
    cen <= 1'b1;
    sen <= 1'b1;
    tick(3);
    chk("clock green", {3'h0, LAMP_GREEN}, {3'h0, l_clk});
    chk("handler green", {3'h0, LAMP_GREEN}, {3'h0, l_sch});
    @(posedge clk);
    cfg <= 1'b1;
    seen_g = 1'b0;
    seen_d = 1'b0;
    for (int i = 0; i < 30; i++) begin
      tick(1);
      seen_g |= (l_clk === LAMP_GREEN);
      seen_d |= (l_clk === LAMP_DARK);
    end
    chk("clock flashing green", 5'h03, {3'h0, seen_g, seen_d});
    @(posedge clk);
    cen <= 1'b0;
    cmd <= 1'b1;
    tick(10);
    chk("clock back to red", {3'h0, LAMP_RED}, {3'h0, l_clk});
    chk("test start pulses", 5'h01, pulses[4:0]);
    // The command stays high through this reset and must not start a test
    power_up(1'b1, 1'b0);
    chk("partial flashes", 5'h06, {1'b0, m_rise});
    chk("failed clock dark", {3'h0, LAMP_DARK}, {3'h0, l_clk});
    chk("no self start", 5'h01, pulses[4:0]);
    conclude();
  end
endmodule
bind tlsi_lamp_ctrl tlsi_lamp_ctrl_properties #(.SEC_DIV(SEC_DIV)) i_props (.I_SYS_CLK(I_SYS_CLK), .I_RST(I_RST),
  .i_card_disabled(i_card_disabled), .i_red_alarm(i_red_alarm), .i_yellow_alarm(i_yellow_alarm),
  .i_loopback(i_loopback), .i_sch_enabled(i_sch_enabled), .i_sch_test_cmd(i_sch_test_cmd),
  .O_CARD_DISABLED_LAMP(O_CARD_DISABLED_LAMP), .O_CARD_ACTIVE_LAMP(O_CARD_ACTIVE_LAMP),
  .O_RED_ALARM_LAMP(O_RED_ALARM_LAMP), .O_FAR_END_ALARM_LAMP(O_FAR_END_ALARM_LAMP),
  .O_LOOPBACK_LAMP(O_LOOPBACK_LAMP), .O_CLKC_LAMP(O_CLKC_LAMP), .O_SCH_LAMP(O_SCH_LAMP),
  .O_SCH_TEST_START(O_SCH_TEST_START), .O_SELFTEST_DONE(O_SELFTEST_DONE));

/* File: rtl/tlsi_lamp_ctrl.sv */
// Faceplate lamp driver for a T1 digital trunk card.
// Assumes status inputs come from card logic on the same clock, and the
// self-test result is settled before the all-lamps-off second ends.
//
// Overview of operation
// - At reset all five main lamps light together for eleven seconds.
// - Then all five main lamps go dark for one second.
// - A passing self-test flashes the five main lamps three times.
// - A partial-failure result flashes them five times instead.
// - After flashing, each main lamp follows its own status condition.
// - Disabled lamp is red while the card is disabled, else dark.
// - Active lamp green only if enabled, alarm free and not in loopback.
// - Red-alarm lamp lit red while a red alarm is present.
// - Far-end alarm lamp lit yellow while a yellow alarm is present.
// - Loopback lamp lit green while the card is in loopback.
// - Clock controller lamp stays dark two seconds after power-up.
// - On clock controller pass its lamp flashes red twice.
// - Then steady red until enabled; then steady or flashing green.
// - Signalling handler lamp is steady red from power-on, no self-test.
// - Signalling handler lamp turns steady green once enabled.
// - Signalling handler test starts only on an explicit software command.
`timescale 1ns/100ps
module tlsi_lamp_ctrl
  import tlsi_pkg::*;
#(
  parameter int SEC_DIV = SEC_CYCLES,
  parameter int BLINK_DIV = BLINK_HALF_CYCLES
) (
  input wire logic I_SYS_CLK,
  input wire logic I_RST,
  input wire logic i_card_disabled,
  input wire logic i_red_alarm,
  input wire logic i_yellow_alarm,
  input wire logic i_loopback,
  input wire logic i_test_partial_fail,
  input wire logic i_clkc_test_pass,
  input wire logic i_clkc_enabled,
  input wire logic i_clkc_flash_green,
  input wire logic i_sch_enabled,
  input wire logic i_sch_test_cmd,
  output logic O_CARD_DISABLED_LAMP,
  output logic O_CARD_ACTIVE_LAMP,
  output logic O_RED_ALARM_LAMP,
  output logic O_FAR_END_ALARM_LAMP,
  output logic O_LOOPBACK_LAMP,
  output logic [1:0] O_CLKC_LAMP,
  output logic [1:0] O_SCH_LAMP,
  output logic O_SCH_TEST_START,
  output logic O_SELFTEST_DONE
);

  // ----------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------
  // True when one more step brings a four-bit count to its end value;
  // the sum stays four bits wide, matching the counters it serves
  function automatic logic step_hits(input logic [3:0] count, input logic [3:0] limit);
    logic [3:0] stepped;
    stepped = count + 4'h1;
    return stepped == limit;
  endfunction

  // Half-periods in a run of on/off flashes; seven flashes at the most
  function automatic logic [3:0] flash_halves(input logic [3:0] flashes);
    return {flashes[2:0], 1'b0};
  endfunction

  // ----------------------------------------------------------------
  // Timebase
  // ----------------------------------------------------------------
  logic sec_tick;
  logic half_tick;

  // One prescaler feeds every sequence, so all lamps share one time grid
  tlsi_timebase #(
    .SEC_DIV(SEC_DIV),
    .BLINK_DIV(BLINK_DIV)
  ) u_timebase (
    .i_clk(I_SYS_CLK),
    .i_rst(I_RST),
    .o_sec_tick(sec_tick),
    .o_half_tick(half_tick)
  );

  // Free blink phase, used for the flashing-green clock controller state
  logic blink_phase;

  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      blink_phase <= 1'b0;
    end else if (half_tick) begin
      blink_phase <= ~blink_phase;
    end
  end

  // ----------------------------------------------------------------
  // Main lamp sequence
  // ----------------------------------------------------------------
  // Four-bit counters: eleven seconds and ten half-periods both fit
  tlsi_main_e main_state;
  tlsi_main_e next_main_state;
  logic [3:0] main_sec;
  logic [3:0] next_main_sec;
  logic [3:0] main_half;
  logic [3:0] next_main_half;
  logic [3:0] flash_target;

  // One flash is an on half-period followed by an off half-period
  wire [3:0] flash_count = i_test_partial_fail ? FLASH_PARTIAL : FLASH_PASS;
  wire main_flash_on = (main_state == MS_FLASH) && ~main_half[0];
  wire test_all_on = (main_state == MS_ALL_ON) || main_flash_on;
  wire main_normal = (main_state == MS_NORMAL);

  // Sequencer transitions; the flash count is latched when flashing starts
  always_comb begin
    next_main_state = main_state;
    next_main_sec = main_sec;
    next_main_half = main_half;
    case (main_state)
      MS_ALL_ON: begin
        if (sec_tick) begin
          next_main_sec = main_sec + 4'h1;
          if (step_hits(main_sec, ALL_ON_SEC)) begin
            next_main_state = MS_ALL_OFF;
            next_main_sec = 4'h0;
          end
        end
      end
      MS_ALL_OFF: begin
        if (sec_tick) begin
          next_main_sec = main_sec + 4'h1;
          if (step_hits(main_sec, ALL_OFF_SEC)) begin
            next_main_state = MS_FLASH;
            next_main_sec = 4'h0;
            next_main_half = 4'h0;
          end
        end
      end
      MS_FLASH: begin
        if (half_tick) begin
          next_main_half = main_half + 4'h1;
          if (step_hits(main_half, flash_halves(flash_target))) begin
            next_main_state = MS_NORMAL;
          end
        end
      end
      default: begin
        next_main_state = MS_NORMAL;
      end
    endcase
  end

  // Sequencer registers; the flash count follows the result only during the all-off second
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      main_state <= MS_ALL_ON;
      main_sec <= 4'h0;
      main_half <= 4'h0;
      flash_target <= FLASH_PASS;
    end else begin
      main_state <= next_main_state;
      main_sec <= next_main_sec;
      main_half <= next_main_half;
      if (main_state == MS_ALL_OFF) begin
        flash_target <= flash_count;
      end
    end
  end

  // ----------------------------------------------------------------
  // Normal status decode
  // ----------------------------------------------------------------
  // Each lamp mirrors one status input; active needs all of them clear
  wire norm_dis = i_card_disabled;
  wire norm_act = ~i_card_disabled & ~i_red_alarm & ~i_yellow_alarm & ~i_loopback;
  wire norm_red = i_red_alarm;
  wire norm_yel = i_yellow_alarm;
  wire norm_lbk = i_loopback;

  // Test pattern overrides status until the sequence completes
  wire next_dis = main_normal ? norm_dis : test_all_on;
  wire next_act = main_normal ? norm_act : test_all_on;
  wire next_red = main_normal ? norm_red : test_all_on;
  wire next_yel = main_normal ? norm_yel : test_all_on;
  wire next_lbk = main_normal ? norm_lbk : test_all_on;

  // Registered so every faceplate output comes straight from a flop
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      O_CARD_DISABLED_LAMP <= 1'b0;
      O_CARD_ACTIVE_LAMP <= 1'b0;
      O_RED_ALARM_LAMP <= 1'b0;
      O_FAR_END_ALARM_LAMP <= 1'b0;
      O_LOOPBACK_LAMP <= 1'b0;
      O_SELFTEST_DONE <= 1'b0;
    end else begin
      O_CARD_DISABLED_LAMP <= next_dis;
      O_CARD_ACTIVE_LAMP <= next_act;
      O_RED_ALARM_LAMP <= next_red;
      O_FAR_END_ALARM_LAMP <= next_yel;
      O_LOOPBACK_LAMP <= next_lbk;
      O_SELFTEST_DONE <= main_normal;
    end
  end

  // ----------------------------------------------------------------
  // Clock controller daughterboard lamp
  // ----------------------------------------------------------------
  // One counter serves the dark seconds and the flash half-periods
  tlsi_clkc_e clkc_state;
  tlsi_clkc_e next_clkc_state;
  logic [3:0] clkc_cnt;
  logic [3:0] next_clkc_cnt;

  // A failed test leaves the lamp dark, a limitation chosen for safety
  always_comb begin
    next_clkc_state = clkc_state;
    next_clkc_cnt = clkc_cnt;
    case (clkc_state)
      CS_DARK: begin
        if (sec_tick) begin
          next_clkc_cnt = clkc_cnt + 4'h1;
          if (step_hits(clkc_cnt, CLKC_DARK_SEC)) begin
            next_clkc_state = CS_WAIT;
            next_clkc_cnt = 4'h0;
          end
        end
      end
      CS_WAIT: begin
        if (i_clkc_test_pass && half_tick) begin
          next_clkc_state = CS_FLASH;
          next_clkc_cnt = 4'h0;
        end
      end
      CS_FLASH: begin
        if (half_tick) begin
          next_clkc_cnt = clkc_cnt + 4'h1;
          if (step_hits(clkc_cnt, flash_halves(FLASH_CLKC))) begin
            next_clkc_state = CS_RED;
          end
        end
      end
      CS_RED: begin
        if (i_clkc_enabled) begin
          next_clkc_state = CS_ENABLED;
        end
      end
      CS_ENABLED: begin
        if (!i_clkc_enabled) begin
          next_clkc_state = CS_RED;
        end
      end
      default: begin
        next_clkc_state = CS_DARK;
      end
    endcase
  end

  // Flashing green is gated by the free blink phase; red flashing starts lit
  wire clkc_green_on = ~i_clkc_flash_green | blink_phase;
  wire [1:0] next_clkc_lamp =
    (clkc_state == CS_FLASH) ? (clkc_cnt[0] ? LAMP_DARK : LAMP_RED) :
    (clkc_state == CS_RED) ? LAMP_RED :
    (clkc_state == CS_ENABLED) ? (clkc_green_on ? LAMP_GREEN : LAMP_DARK) :
    LAMP_DARK;

  // Controller lamp registers
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      clkc_state <= CS_DARK;
      clkc_cnt <= 4'h0;
      O_CLKC_LAMP <= LAMP_DARK;
    end else begin
      clkc_state <= next_clkc_state;
      clkc_cnt <= next_clkc_cnt;
      O_CLKC_LAMP <= next_clkc_lamp;
    end
  end

  // ----------------------------------------------------------------
  // Signalling channel handler lamp and manual test request
  // ----------------------------------------------------------------
  // Edge detector for the manual test command
  logic sch_cmd_prev;
  wire sch_cmd_rise = i_sch_test_cmd & ~sch_cmd_prev;

  // No self-test at power-on; red is shown from reset until enabled.
  // The detector resets as if the command were already high, so a command
  // left asserted through reset never starts a test by itself.
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      O_SCH_LAMP <= LAMP_RED;
      sch_cmd_prev <= 1'b1;
      O_SCH_TEST_START <= 1'b0;
    end else begin
      O_SCH_LAMP <= i_sch_enabled ? LAMP_GREEN : LAMP_RED;
      sch_cmd_prev <= i_sch_test_cmd;
      O_SCH_TEST_START <= sch_cmd_rise;
    end
  end

endmodule

/* File: rtl/tlsi_pkg.sv */
// Constants shared by the trunk card lamp sequencer.
// Assumes a single card clock at 100 MHz and a synchronous reset.
package tlsi_pkg;

  // ----------------------------------------------------------------
  // Clock and timebase
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 100000000;
  localparam int SEC_CYCLES = CLK_HZ; // One second in clock cycles
  localparam int BLINK_HALF_MS = 250; // Default blink half-period in ms
  localparam int BLINK_HALF_CYCLES = (CLK_HZ / 1000) * BLINK_HALF_MS;

  // ----------------------------------------------------------------
  // Power-on sequence timing, in seconds
  // ----------------------------------------------------------------
  localparam logic [3:0] ALL_ON_SEC = 4'hB; // Eleven seconds
  localparam logic [3:0] ALL_OFF_SEC = 4'h1; // One second
  localparam logic [3:0] CLKC_DARK_SEC = 4'h2; // Two seconds

  // ----------------------------------------------------------------
  // Flash counts
  // ----------------------------------------------------------------
  localparam logic [3:0] FLASH_PASS = 4'h3;
  localparam logic [3:0] FLASH_PARTIAL = 4'h5;
  localparam logic [3:0] FLASH_CLKC = 4'h2;

  // ----------------------------------------------------------------
  // Lamp colour encoding {green, red}; yellow has its own pin
  // ----------------------------------------------------------------
  localparam logic [1:0] LAMP_DARK = 2'h0;
  localparam logic [1:0] LAMP_RED = 2'h1;
  localparam logic [1:0] LAMP_GREEN = 2'h2;

  typedef enum {
    MS_ALL_ON,
    MS_ALL_OFF,
    MS_FLASH,
    MS_NORMAL
  } tlsi_main_e;

  typedef enum {
    CS_DARK,
    CS_WAIT,
    CS_FLASH,
    CS_RED,
    CS_ENABLED
  } tlsi_clkc_e;

endpackage

/* File: rtl/tlsi_timebase.sv */
// Prescaler giving a one-cycle seconds tick and a one-cycle blink half-period tick.
// Assumes it runs on the card clock with the shared synchronous reset.
`timescale 1ns/100ps
module tlsi_timebase
  import tlsi_pkg::*;
#(
  parameter int SEC_DIV = SEC_CYCLES,
  parameter int BLINK_DIV = BLINK_HALF_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_rst,
  output logic o_sec_tick,
  output logic o_half_tick
);

  // ----------------------------------------------------------------
  // Counters
  // ----------------------------------------------------------------
  logic [31:0] sec_cnt;
  logic [31:0] half_cnt;
  wire sec_wrap = (sec_cnt == 32'(SEC_DIV - 1));
  wire half_wrap = (half_cnt == 32'(BLINK_DIV - 1));

  // Free running; restarted by reset so the sequence timing is exact
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sec_cnt <= 32'h0;
      half_cnt <= 32'h0;
      o_sec_tick <= 1'b0;
      o_half_tick <= 1'b0;
    end else begin
      sec_cnt <= sec_wrap ? 32'h0 : sec_cnt + 32'h1;
      half_cnt <= half_wrap ? 32'h0 : half_cnt + 32'h1;
      o_sec_tick <= sec_wrap;
      o_half_tick <= half_wrap;
    end
  end

endmodule
